// [rtl/ufdr_top.sv]
`timescale 1ns/1ps
module ufdr_top #(
	parameter int FIFO_DEPTH = ufdr_pkg::FIFO_DEPTH
) (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic ce,
	input wire logic [5:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [5:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic sample_tick,
	input wire logic sampling_rate_select,
	input wire logic rx_line,
	output logic tx_line,
	input wire logic cts_n,
	output logic rts_n,
	output logic int_req
);
	import ufdr_pkg::*;

	localparam int PW = $clog2(FIFO_DEPTH);
	localparam int CW = PW + 1;
	localparam int RW = DATA_W + TAG_W;

	typedef enum logic [2:0] {
		UFDR_IDLE = 3'b000,
		UFDR_START = 3'b001,
		UFDR_DATA = 3'b010,
		UFDR_PAR = 3'b011,
		UFDR_STOP = 3'b100
	} ufdr_ser_e;

	typedef struct packed {
		logic aw_hold;
		logic [5:0] aw_addr;
		logic w_hold;
		logic [7:0] w_data;
		logic w_lane0;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
		logic [7:0] interrupt_enable;
		logic fifo_en;
		logic [1:0] rx_trig;
		logic [1:0] tx_trig;
		logic [4:0] line_control;
		logic mcr_rts;
		logic efr_enh;
		logic efr_arts;
		logic efr_acts;
		logic [PW-1:0] tx_wp;
		logic [PW-1:0] tx_rp;
		logic [CW-1:0] tx_cnt;
		ufdr_ser_e tx_state;
		logic [3:0] tx_sub;
		logic [2:0] tx_bit;
		logic [7:0] tx_shift;
		logic tx_par;
		logic tx_line;
		logic [PW-1:0] rx_wp;
		logic [PW-1:0] rx_rp;
		logic [CW-1:0] rx_cnt;
		ufdr_ser_e rx_state;
		logic [3:0] rx_sub;
		logic [2:0] rx_bit;
		logic [7:0] rx_shift;
		logic rx_par;
		logic rx_perr;
		logic rx_prev;
		logic rx_ovr;
		logic [TO_W-1:0] to_cnt;
		logic rx_to;
		logic rts_off;
		logic rts_n;
		logic flow_flag;
	} ufdr_state_s;

	ufdr_state_s st;
	ufdr_state_s next_st;
	logic [7:0] tx_rd_data;
	logic [RW-1:0] rx_rd_data;
	logic tx_push;
	logic tx_pop;
	logic rx_push;
	logic [RW-1:0] rx_wd;
	logic rx_pop;
	logic tx_emp_int;
	logic rx_rdy_int;
	logic [7:0] isr_val;
	logic [7:0] lsr_val;

	ufdr_mem #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_tx_mem (
		.sys_clk(sys_clk),
		.en(ce),
		.we(tx_push),
		.wr_addr(st.tx_wp),
		.wr_data(st.w_data),
		.rd_addr(next_st.tx_rp),
		.rd_data(tx_rd_data)
	);

	ufdr_mem #(.WIDTH(RW), .DEPTH(FIFO_DEPTH)) u_rx_mem (
		.sys_clk(sys_clk),
		.en(ce),
		.we(rx_push),
		.wr_addr(st.rx_wp),
		.wr_data(rx_wd),
		.rd_addr(next_st.rx_rp),
		.rd_data(rx_rd_data)
	);

	// Interrupt and line status views
	always_comb
	begin
		tx_emp_int = st.interrupt_enable[IER_TX] && (st.fifo_en // R04
			? st.tx_cnt < CW'(ufdr_trig(st.tx_trig)) // R07
			: st.tx_cnt == '0);
		rx_rdy_int = st.interrupt_enable[IER_RX] && (st.fifo_en // R14
			? st.rx_cnt >= CW'(ufdr_trig(st.rx_trig))
			: st.rx_cnt != '0);
		isr_val = 8'h00;
		isr_val[1] = tx_emp_int;
		isr_val[2] = rx_rdy_int;
		isr_val[3] = st.rx_to && st.interrupt_enable[IER_RX];
		isr_val[5] = st.flow_flag;
		isr_val[0] = |isr_val[7:1];
		lsr_val = 8'h00;
		lsr_val[0] = st.rx_cnt != '0;
		lsr_val[1] = st.rx_ovr;
		lsr_val[4:2] = lsr_val[0] ? rx_rd_data[RW-1:DATA_W] : 3'h0; // R11
		lsr_val[5] = st.tx_cnt == '0; // R03 R06
		lsr_val[6] = st.tx_cnt == '0 && st.tx_state == UFDR_IDLE; // R05 R08
	end

	always_comb
	begin
		logic [3:0] bit_m1;
		logic [3:0] half_m1;
		logic [2:0] nbits_m1;
		logic [CW-1:0] cap;
		logic [TO_W-1:0] to_limit;
		logic tx_clr;
		logic rx_clr;
		logic bit_end;
		next_st = st;
		tx_push = 1'b0;
		tx_pop = 1'b0;
		rx_push = 1'b0;
		rx_pop = 1'b0;
		rx_wd = '0;
		tx_clr = 1'b0;
		rx_clr = 1'b0;
		bit_m1 = sampling_rate_select ? BIT16_M1 : BIT8_M1; // R23
		half_m1 = sampling_rate_select ? HALF16_M1 : HALF8_M1; // R09
		nbits_m1 = 3'h4 + {1'b0, st.line_control[1:0]};
		cap = st.fifo_en ? CW'(FIFO_DEPTH) : CW'(1); // R25
		to_limit = TO_W'((TO_WORDS * (WL_BASE + int'(st.line_control[1:0]))
			+ TO_BITS) * (int'(bit_m1) + 1)); // R15
		bit_end = 1'b0;

		// Register bus, write side
		if (s_axi_awvalid && s_axi_awready)
		begin
			next_st.aw_hold = 1'b1;
			next_st.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			next_st.w_hold = 1'b1;
			next_st.w_data = s_axi_wdata[7:0];
			next_st.w_lane0 = s_axi_wstrb[0];
		end
		if (st.bvalid && s_axi_bready)
			next_st.bvalid = 1'b0;
		if (st.aw_hold && st.w_hold && !st.bvalid)
		begin
			next_st.aw_hold = 1'b0;
			next_st.w_hold = 1'b0;
			next_st.bvalid = 1'b1;
			next_st.bresp = RESP_OKAY;
			case ({st.aw_addr[5:2], 2'b00})
				OFS_DATA:
					if (st.w_lane0 && st.tx_cnt < cap)
						tx_push = 1'b1; // R02
				OFS_IER:
					if (st.w_lane0)
					begin
						next_st.interrupt_enable[3:0] = st.w_data[3:0];
						if (st.efr_enh)
							next_st.interrupt_enable[7:4] = st.w_data[7:4]; // R17
					end
				OFS_FCR:
					if (st.w_lane0)
					begin
						next_st.fifo_en = st.w_data[FCR_EN];
						rx_clr = st.w_data[FCR_RXRST]
							|| st.w_data[FCR_EN] != st.fifo_en;
						tx_clr = st.w_data[FCR_TXRST]
							|| st.w_data[FCR_EN] != st.fifo_en;
					end
				OFS_LCR:
					if (st.w_lane0)
						next_st.line_control = st.w_data[4:0];
				OFS_MCR:
					if (st.w_lane0)
						next_st.mcr_rts = st.w_data[MCR_RTS]; // R16
				OFS_EFR:
					if (st.w_lane0)
					begin
						next_st.efr_enh = st.w_data[EFR_ENH];
						next_st.efr_arts = st.w_data[EFR_ARTS]; // R16
						next_st.efr_acts = st.w_data[EFR_ACTS]; // R20
					end
				OFS_TRIG:
					if (st.w_lane0)
					begin
						next_st.rx_trig = st.w_data[1:0];
						next_st.tx_trig = st.w_data[5:4];
					end
				OFS_ISR, OFS_LSR:
					next_st.bresp = RESP_OKAY;
				default:
					next_st.bresp = RESP_SLVERR;
			endcase
		end

		// Register bus, read side
		if (st.rvalid && s_axi_rready)
			next_st.rvalid = 1'b0;
		if (s_axi_arvalid && s_axi_arready)
		begin
			next_st.rvalid = 1'b1;
			next_st.rresp = RESP_OKAY;
			next_st.rdata = 32'h0000_0000;
			case ({s_axi_araddr[5:2], 2'b00})
				OFS_DATA:
					if (st.rx_cnt != '0)
					begin
						next_st.rdata[7:0] = rx_rd_data[7:0];
						rx_pop = 1'b1; // R13
						next_st.to_cnt = '0;
						next_st.rx_to = 1'b0;
					end
				OFS_IER:
					next_st.rdata[7:0] = st.interrupt_enable;
				OFS_ISR:
				begin
					next_st.rdata[7:0] = isr_val;
					next_st.flow_flag = 1'b0;
				end
				OFS_FCR:
					next_st.rdata[FCR_EN] = st.fifo_en;
				OFS_LCR:
					next_st.rdata[4:0] = st.line_control;
				OFS_LSR:
				begin
					next_st.rdata[7:0] = lsr_val;
					next_st.rx_ovr = 1'b0;
				end
				OFS_MCR:
					next_st.rdata[MCR_RTS] = st.mcr_rts;
				OFS_EFR:
				begin
					next_st.rdata[EFR_ENH] = st.efr_enh;
					next_st.rdata[EFR_ARTS] = st.efr_arts;
					next_st.rdata[EFR_ACTS] = st.efr_acts;
				end
				OFS_TRIG:
					next_st.rdata[7:0] = {2'b00, st.tx_trig, 2'b00, st.rx_trig};
				default:
					next_st.rresp = RESP_SLVERR;
			endcase
		end

		// Transmitter
		if (sample_tick)
		begin
			bit_end = st.tx_sub == bit_m1;
			next_st.tx_sub = bit_end ? 4'h0 : st.tx_sub + 4'h1;
			case (st.tx_state)
				UFDR_IDLE:
				begin
					next_st.tx_sub = 4'h0;
					if (st.tx_cnt != '0 && !(st.efr_acts && cts_n)) // R21
					begin
						tx_pop = 1'b1; // R03
						next_st.tx_shift = tx_rd_data;
						next_st.tx_state = UFDR_START;
						next_st.tx_line = 1'b0; // R01
						next_st.tx_par = 1'b0;
					end
				end
				UFDR_START, UFDR_DATA:
					if (bit_end)
					begin
						if (st.tx_state == UFDR_DATA && st.tx_bit == nbits_m1)
						begin
							next_st.tx_bit = 3'h0;
							if (st.line_control[LCR_PAREN])
							begin
								next_st.tx_state = UFDR_PAR;
								next_st.tx_line = st.tx_par ^ ~st.line_control[LCR_EVEN];
							end
							else
							begin
								next_st.tx_state = UFDR_STOP;
								next_st.tx_line = 1'b1;
							end
						end
						else
						begin
							if (st.tx_state == UFDR_DATA)
								next_st.tx_bit = st.tx_bit + 3'h1;
							next_st.tx_state = UFDR_DATA;
							next_st.tx_line = st.tx_shift[0]; // R01
							next_st.tx_par = st.tx_par ^ st.tx_shift[0];
							next_st.tx_shift = {1'b0, st.tx_shift[7:1]};
						end
					end
				UFDR_PAR:
					if (bit_end)
					begin
						next_st.tx_state = UFDR_STOP;
						next_st.tx_line = 1'b1;
					end
				UFDR_STOP:
					if (bit_end)
					begin
						if (st.line_control[LCR_STOP2] && st.tx_bit == 3'h0)
							next_st.tx_bit = 3'h1;
						else
						begin
							next_st.tx_bit = 3'h0;
							next_st.tx_state = UFDR_IDLE;
						end
					end
				default:
					next_st.tx_state = UFDR_IDLE;
			endcase
		end

		// Receiver
		if (sample_tick)
		begin
			next_st.rx_prev = rx_line;
			bit_end = st.rx_sub == bit_m1;
			next_st.rx_sub = bit_end ? 4'h0 : st.rx_sub + 4'h1;
			case (st.rx_state)
				UFDR_IDLE:
				begin
					next_st.rx_sub = 4'h0;
					if (st.rx_prev && !rx_line)
						next_st.rx_state = UFDR_START; // R09
				end
				UFDR_START:
					if (st.rx_sub == half_m1)
					begin
						next_st.rx_sub = 4'h0;
						next_st.rx_bit = 3'h0;
						next_st.rx_par = 1'b0;
						next_st.rx_perr = 1'b0;
						next_st.rx_shift = 8'h00;
						next_st.rx_state = rx_line ? UFDR_IDLE : UFDR_DATA; // R24
					end
				UFDR_DATA:
					if (bit_end) // R10
					begin
						next_st.rx_shift = {rx_line, st.rx_shift[7:1]};
						next_st.rx_par = st.rx_par ^ rx_line;
						next_st.rx_bit = st.rx_bit + 3'h1;
						if (st.rx_bit == nbits_m1)
							next_st.rx_state = st.line_control[LCR_PAREN]
								? UFDR_PAR : UFDR_STOP;
					end
				UFDR_PAR:
					if (bit_end)
					begin
						next_st.rx_perr = st.rx_par ^ rx_line ^ ~st.line_control[LCR_EVEN];
						next_st.rx_state = UFDR_STOP;
					end
				UFDR_STOP:
					if (bit_end)
					begin
						next_st.rx_state = UFDR_IDLE;
						rx_wd = {st.rx_shift == 8'h00 && !rx_line, !rx_line,
							st.rx_perr, st.rx_shift >> (2'h3 - st.line_control[1:0])}; // R12
						if (st.rx_cnt < cap)
							rx_push = 1'b1; // R18
						else
							next_st.rx_ovr = 1'b1;
					end
				default:
					next_st.rx_state = UFDR_IDLE;
			endcase
			// Silence counter while data waits
			if (st.rx_cnt == '0 || rx_push || rx_pop)
				next_st.to_cnt = '0;
			else if (st.to_cnt == to_limit)
				next_st.rx_to = 1'b1; // R15
			else
				next_st.to_cnt = st.to_cnt + TO_W'(1);
		end
		if (st.rx_cnt == '0)
			next_st.rx_to = 1'b0;

		// Pointer and level bookkeeping
		if (tx_clr)
		begin
			tx_push = 1'b0;
			next_st.tx_wp = '0;
			next_st.tx_rp = '0;
			next_st.tx_cnt = '0;
		end
		else
		begin
			next_st.tx_wp = st.tx_wp + PW'(tx_push); // R02
			next_st.tx_rp = st.tx_rp + PW'(tx_pop);
			next_st.tx_cnt = st.tx_cnt + CW'(tx_push) - CW'(tx_pop);
		end
		if (rx_clr)
		begin
			rx_push = 1'b0;
			next_st.rx_wp = '0;
			next_st.rx_rp = '0;
			next_st.rx_cnt = '0;
		end
		else
		begin
			next_st.rx_wp = st.rx_wp + PW'(rx_push);
			next_st.rx_rp = st.rx_rp + PW'(rx_pop); // R13
			next_st.rx_cnt = st.rx_cnt + CW'(rx_push) - CW'(rx_pop);
		end

		// Flow control
		if (!(st.efr_arts && st.mcr_rts)) // R16
			next_st.rts_off = 1'b0;
		else if (next_st.rx_cnt >= CW'(ufdr_trig_hi(st.rx_trig))) // R19
			next_st.rts_off = 1'b1; // R18
		else if (next_st.rx_cnt <= CW'(ufdr_trig_lo(st.rx_trig)))
			next_st.rts_off = 1'b0; // R18
		next_st.rts_n = !next_st.mcr_rts || next_st.rts_off;
		if (!st.rts_n && next_st.rts_n && st.interrupt_enable[IER_RTS])
			next_st.flow_flag = 1'b1; // R17
		if (st.interrupt_enable[IER_CTS] && cts_n)
			next_st.flow_flag = 1'b1; // R20
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rstn)
		begin
			st <= '0;
			st.line_control <= RST_LCR;
			st.tx_line <= 1'b1;
			st.rx_prev <= 1'b1;
			st.rts_n <= 1'b1;
		end
		else if (ce)
			st <= next_st;
	end

	assign s_axi_awready = !st.aw_hold && !st.bvalid;
	assign s_axi_wready = !st.w_hold && !st.bvalid;
	assign s_axi_bvalid = st.bvalid;
	assign s_axi_bresp = st.bresp;
	assign s_axi_arready = !st.rvalid;
	assign s_axi_rvalid = st.rvalid;
	assign s_axi_rdata = st.rdata;
	assign s_axi_rresp = st.rresp;
	assign tx_line = st.tx_line;
	assign rts_n = st.rts_n;
	assign int_req = isr_val[0];
endmodule

// [rtl/ufdr_pkg.sv]
// Behaviour
// R01: Each written byte goes out LSB first with start, data, parity, stop bits.
// R02: FIFO enabled: each holding write enters 128-byte transmit FIFO, pointer advances.
// R03: Non-FIFO: holding-empty status bit 5 sets when byte moves to shifter.
// R04: Transmit-empty interrupt status bit 1 only while enable bit 1 set.
// R05: Non-FIFO: transmitter-empty bit 6 sets once shifter fully shifted out.
// R06: FIFO mode: holding-empty bit 5 set whenever transmit FIFO is empty.
// R07: FIFO mode: transmit-empty interrupt when fill falls below transmit trigger.
// R08: FIFO mode: transmitter-empty bit 6 only when FIFO and shifter empty.
// R09: Falling edge starts count; sample after 8 (16X) or 4 (8X) clocks.
// R10: Data, parity and stop bits sampled at centre, same count as start.
// R11: Errors of head character shown in line status bits 2 to 4.
// R12: Receive FIFO is 128 entries of 8 data plus 3 error tag bits.
// R13: Holding read pops FIFO, presents next byte, updates error bits at once.
// R14: Receive-ready interrupt per character or at trigger, gated by enable bit 0.
// R15: Waiting data plus four words and 12 bits of silence raises timeout.
// R16: Auto RTS needs feature bit 6 and host setting modem control bit 1.
// R17: Enable bit 6 writable after feature bit 4; RTS rise sets status bit 5.
// R18: Auto RTS: off at upper limit, on at lower limit, accept until full.
// R19: Upper limit is next higher trigger level, lower is next lower.
// R20: Auto CTS needs feature bit 7; high CTS with enable bit 7 sets bit 5.
// R21: Auto CTS high: finish current character, start none, resume when low.
// R22: Remote transmitter stops after its shifter empties once RTS deasserted.
// R23: Bit period is 16 sampling clocks in 16X mode, 8 in 8X mode.
// R24: Start bit failing centre check is dropped; wait for next falling edge.
// R25: FIFO disabled: each path acts as a single-byte holding register.
package ufdr_pkg;
	localparam int FIFO_DEPTH = 128;
	localparam int DATA_W = 8;
	localparam int TAG_W = 3;
	localparam logic [5:0] OFS_DATA = 6'h00;
	localparam logic [5:0] OFS_IER = 6'h04;
	localparam logic [5:0] OFS_ISR = 6'h08;
	localparam logic [5:0] OFS_FCR = 6'h0C;
	localparam logic [5:0] OFS_LCR = 6'h10;
	localparam logic [5:0] OFS_LSR = 6'h14;
	localparam logic [5:0] OFS_MCR = 6'h18;
	localparam logic [5:0] OFS_EFR = 6'h1C;
	localparam logic [5:0] OFS_TRIG = 6'h20;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam int IER_RX = 0;
	localparam int IER_TX = 1;
	localparam int IER_RTS = 6;
	localparam int IER_CTS = 7;
	localparam int FCR_EN = 0;
	localparam int FCR_RXRST = 1;
	localparam int FCR_TXRST = 2;
	localparam int EFR_ENH = 4;
	localparam int EFR_ARTS = 6;
	localparam int EFR_ACTS = 7;
	localparam int MCR_RTS = 1;
	localparam int LCR_STOP2 = 2;
	localparam int LCR_PAREN = 3;
	localparam int LCR_EVEN = 4;
	localparam logic [4:0] RST_LCR = 5'h03;
	localparam logic [3:0] BIT16_M1 = 4'hF;
	localparam logic [3:0] BIT8_M1 = 4'h7;
	localparam logic [3:0] HALF16_M1 = 4'h7;
	localparam logic [3:0] HALF8_M1 = 4'h3;
	localparam int TO_WORDS = 4;
	localparam int TO_BITS = 12;
	localparam int WL_BASE = 5;
	localparam int TO_W = 10;

	function automatic logic [7:0] ufdr_trig(input logic [1:0] idx);
		case (idx)
			2'h0: ufdr_trig = 8'h08;
			2'h1: ufdr_trig = 8'h10;
			2'h2: ufdr_trig = 8'h18;
			default: ufdr_trig = 8'h1C;
		endcase
	endfunction

	// Hysteresis limits from neighbouring table entries; 8'h20 above the top entry and 8'h00 below the first
	function automatic logic [7:0] ufdr_trig_hi(input logic [1:0] idx);
		ufdr_trig_hi = (idx == 2'h3) ? 8'h20 : ufdr_trig(idx + 2'h1);
	endfunction

	function automatic logic [7:0] ufdr_trig_lo(input logic [1:0] idx);
		ufdr_trig_lo = (idx == 2'h0) ? 8'h00 : ufdr_trig(idx - 2'h1);
	endfunction
endpackage

// [rtl/ufdr_mem.sv]
`timescale 1ns/1ps
module ufdr_mem #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 128,
	parameter int AW = $clog2(DEPTH)
) (
	input wire logic sys_clk,
	input wire logic en,
	input wire logic we,
	input wire logic [AW-1:0] wr_addr,
	input wire logic [WIDTH-1:0] wr_data,
	input wire logic [AW-1:0] rd_addr,
	output logic [WIDTH-1:0] rd_data
);
	logic [WIDTH-1:0] mem [DEPTH];

	always_ff @(posedge sys_clk)
	begin
		if (en)
		begin
			if (we)
				mem[wr_addr] <= wr_data;
			// Write-through so a just-written head is seen next cycle
			if (we && wr_addr == rd_addr)
				rd_data <= wr_data;
			else
				rd_data <= mem[rd_addr];
		end
	end
endmodule

// [sim/ufdr_remote.sv]
`timescale 1ns/1ps
module ufdr_remote (
	input wire logic sys_clk,
	input wire logic sample_tick,
	input wire logic sampling_rate_select,
	input wire logic tx_line,
	input wire logic rts_n,
	output logic rx_line
);
	logic [7:0] got[$];
	logic line_q = 1'b1;
	int bt;
	assign rx_line = line_q;
	assign bt = sampling_rate_select ? 16 : 8;
	task automatic ticks(input int n);
		repeat (n) @(posedge sys_clk iff sample_tick);
	endtask
	// Frame starts only while the device asks for data
	task automatic send(input logic [7:0] b, input logic stp);
		while (rts_n !== 1'b0)
			@(posedge sys_clk);
		line_q <= 1'b0;
		ticks(bt);
		for (int i = 0; i < 8; i++)
		begin
			line_q <= b[i];
			ticks(bt);
		end
		line_q <= stp;
		ticks(bt);
		line_q <= 1'b1;
		ticks(bt);
	endtask
	// Low pulse far shorter than half a bit
	task automatic glitch();
		line_q <= 1'b0;
		ticks(2);
		line_q <= 1'b1;
		ticks(12 * bt);
	endtask
	// Capture device frames at bit centres
	always
	begin : cap
		logic [7:0] d;
		@(posedge sys_clk iff (sample_tick && tx_line === 1'b0));
		ticks(bt / 2);
		for (int i = 0; i < 8; i++)
		begin
			ticks(bt);
			d[i] = tx_line;
		end
		ticks(bt);
		got.push_back(d);
	end
endmodule

// [sim/ufdr_top_asserts.sv]
`timescale 1ns/1ps
module ufdr_top_asserts (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic tx_line,
	input wire logic rts_n,
	input wire logic int_req
);
	default clocking @(posedge sys_clk);
	endclocking
	default disable iff (!rstn);
	a_write_answer:
	assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready |=> ##1 s_axi_bvalid)
		else $error("write unanswered");
	a_bresp_stands:
	assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp moved");
	a_write_refused:
	assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken during response");
	a_read_answer:
	assert property (s_axi_arvalid && s_axi_arready
		|=> s_axi_rvalid && !s_axi_arready) else $error("read unanswered");
	a_rdata_stands:
	assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata moved");
	a_rdata_byte:
	assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
		else $error("rdata upper bits set");
	a_start_low:
	assert property ($fell(tx_line) |-> !tx_line [*8])
		else $error("start bit too short");
	a_reset_idle:
	assert property ($rose(rstn) |-> tx_line && rts_n && !int_req)
		else $error("outputs not idle after reset");
	c_write: cover property (s_axi_bvalid && s_axi_bready);
	c_frame: cover property ($fell(tx_line));
	c_rts_off: cover property ($rose(rts_n));
endmodule
bind ufdr_top ufdr_top_asserts ufdr_top_asserts_inst (
	.sys_clk(sys_clk), .rstn(rstn), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .tx_line(tx_line), .rts_n(rts_n),
	.int_req(int_req)
);

// [sim/test_ufdr_top.sv]
`timescale 1ns/1ps
module test_ufdr_top;
	import ufdr_pkg::*;
	logic sys_clk, rstn, awvalid, wvalid, bready, arvalid, rready;
	logic awready, wready, bvalid, arready, rvalid, cts_n;
	logic tick = 1'b0;
	logic sampling_rate_select = 1'b1;
	logic tx_line, rx_line, rts_n, int_req;
	logic [5:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [1:0] bresp, rresp;
	int mismatches = 0, tests_run = 0, cyc = 0;
	initial
	begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk)
		tick <= ~tick;
	always @(posedge sys_clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 30000)
		begin
			mismatches = mismatches + 1;
			wrap_up();
		end
	end
	ufdr_top ufdr_top_inst (
		.sys_clk(sys_clk), .rstn(rstn), .ce(1'b1),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .sample_tick(tick),
		.sampling_rate_select(sampling_rate_select), .rx_line(rx_line),
		.tx_line(tx_line), .cts_n(cts_n), .rts_n(rts_n),
		.int_req(int_req)
	);
	ufdr_remote ufdr_remote_inst (
		.sys_clk(sys_clk), .sample_tick(tick), .tx_line(tx_line),
		.sampling_rate_select(sampling_rate_select),
		.rts_n(rts_n), .rx_line(rx_line)
	);
	task automatic chk(input string n, input logic [31:0] e,
		input logic [31:0] g);
		tests_run++;
		if (g !== e)
		begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		logic [1:0] x;
		@(posedge sys_clk);
		awaddr <= a;
		wdata <= {24'h000000, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		fork
			@(posedge sys_clk iff awready) awvalid <= 1'b0;
			@(posedge sys_clk iff wready) wvalid <= 1'b0;
		join
		@(posedge sys_clk iff bvalid);
		bready <= 1'b0;
		x = (a > OFS_TRIG) ? RESP_SLVERR : RESP_OKAY;
		chk("bresp", {30'h0, x}, {30'h0, bresp});
	endtask
	task automatic rc(input string n, input logic [5:0] a,
		input logic [31:0] e);
		logic [1:0] x;
		@(posedge sys_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		@(posedge sys_clk iff arready);
		arvalid <= 1'b0;
		@(posedge sys_clk iff rvalid);
		rready <= 1'b0;
		x = (a > OFS_TRIG) ? RESP_SLVERR : RESP_OKAY;
		chk("rresp", {30'h0, x}, {30'h0, rresp});
		if (x == RESP_OKAY)
			chk(n, e, rdata);
	endtask
	task automatic ct(input int i, input logic [7:0] e);
		chk("tx_byte", {24'h0, e}, {24'h0, ufdr_remote_inst.got[i]});
	endtask
	task automatic wq(input int n);
		while (ufdr_remote_inst.got.size() < n)
			@(posedge sys_clk);
	endtask
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial
	begin
		{rstn, awvalid, wvalid, bready, arvalid, rready, cts_n} = '0;
		{awaddr, araddr, wdata} = '0;
		repeat (20) @(posedge sys_clk);
		rstn <= 1'b1;
		rc("line_status", OFS_LSR, 32'h60);
		rc("line_control", OFS_LCR, 32'h03);
		rc("unmapped", 6'h24, 32'h0);
		wr(6'h28, 8'h01);
		$display("test reset done");
		wr(OFS_IER, 8'h02);
		rc("isr_tx", OFS_ISR, 32'h03);
		wr(OFS_DATA, 8'hA5);
		wr(OFS_DATA, 8'h5A);
		rc("lsr_busy", OFS_LSR, 32'h00);
		wq(2);
		ct(0, 8'hA5);
		ct(1, 8'h5A);
		repeat (40) @(posedge sys_clk);
		rc("lsr_done", OFS_LSR, 32'h60);
		wr(OFS_IER, 8'h00);
		chk("int_off", 32'h0, {31'h0, int_req});
		$display("test single transmit done");
		wr(OFS_FCR, 8'h01);
		wr(OFS_IER, 8'h02);
		rc("isr_fifo", OFS_ISR, 32'h03);
		for (int i = 1; i < 4; i++)
			wr(OFS_DATA, 8'(8'h11 * i));
		rc("lsr_fifo", OFS_LSR, 32'h00);
		wq(5);
		for (int i = 2; i < 5; i++)
			ct(i, 8'(8'h11 * (i - 1)));
		repeat (40) @(posedge sys_clk);
		rc("lsr_fifo_done", OFS_LSR, 32'h60);
		wr(OFS_IER, 8'h00);
		$display("test fifo transmit done");
		wr(OFS_MCR, 8'h02);
		wr(OFS_IER, 8'h01);
		ufdr_remote_inst.send(8'h3C, 1'b0);
		ufdr_remote_inst.send(8'hC3, 1'b1);
		rc("lsr_err", OFS_LSR, 32'h69);
		rc("rx_data", OFS_DATA, 32'h3C);
		rc("lsr_next", OFS_LSR, 32'h61);
		rc("rx_data", OFS_DATA, 32'hC3);
		ufdr_remote_inst.send(8'h77, 1'b1);
		chk("int_early", 32'h0, {31'h0, int_req});
		while (int_req !== 1'b1)
			@(posedge sys_clk);
		rc("isr_timeout", OFS_ISR, 32'h09);
		rc("rx_data", OFS_DATA, 32'h77);
		wr(OFS_FCR, 8'h00);
		ufdr_remote_inst.glitch();
		rc("lsr_glitch", OFS_LSR, 32'h60);
		ufdr_remote_inst.send(8'h81, 1'b1);
		while (int_req !== 1'b1)
			@(posedge sys_clk);
		rc("isr_rx", OFS_ISR, 32'h05);
		rc("rx_data", OFS_DATA, 32'h81);
		chk("int_clear", 32'h0, {31'h0, int_req});
		$display("test receive done");
		wr(OFS_EFR, 8'h90);
		wr(OFS_IER, 8'h80);
		cts_n <= 1'b1;
		wr(OFS_DATA, 8'h5C);
		repeat (800) @(posedge sys_clk);
		chk("tx_held", 32'h5, 32'(ufdr_remote_inst.got.size()));
		rc("isr_cts", OFS_ISR, 32'h21);
		cts_n <= 1'b0;
		wq(6);
		ct(5, 8'h5C);
		wr(OFS_IER, 8'h00);
		rc("isr_sticky", OFS_ISR, 32'h21);
		$display("test auto cts done");
		wr(OFS_FCR, 8'h01);
		wr(OFS_EFR, 8'h50);
		wr(OFS_IER, 8'h40);
		chk("rts_on", 32'h0, {31'h0, rts_n});
		for (int i = 0; i < 16; i++)
			ufdr_remote_inst.send(8'(8'h40 + i), 1'b1);
		repeat (4) @(posedge sys_clk);
		chk("rts_off", 32'h1, {31'h0, rts_n});
		rc("isr_rts", OFS_ISR, 32'h21);
		for (int i = 0; i < 15; i++)
			rc("rx_fill", OFS_DATA, 32'h40 + i);
		chk("rts_hold", 32'h1, {31'h0, rts_n});
		rc("rx_fill", OFS_DATA, 32'h4F);
		repeat (2) @(posedge sys_clk);
		chk("rts_back", 32'h0, {31'h0, rts_n});
		$display("test auto rts done");
		sampling_rate_select <= 1'b0;
		wr(OFS_DATA, 8'h96);
		ufdr_remote_inst.send(8'h69, 1'b1);
		wq(7);
		ct(6, 8'h96);
		rc("rx_8x", OFS_DATA, 32'h69);
		$display("test 8x sampling done");
		wrap_up();
	end
endmodule
